// File: logic/video_forwarding_control.sv
`timescale 1ns/100ps
`include "fwd_consts.svh"
// How it works
// - synced mode waits until every enabled port has a line before sending.
// - send-as-available bit forwards each port's line once it is ready.
// - send-as-available ignored in concatenation; never touches sync short packets.
// - mode field bits 3:2: off, basic, interleave, concatenate.
// - round-robin mode serves pending ports in turn without alignment.
// - reset leaves round-robin on and synced forwarding off.
// - failure flag sets on sync loss, only after one synced frame.
// - reading the status register clears the failure flag.
// - synchronized bit high while synced video is being delivered.
// - synchronized bit zero whenever synced forwarding is off.
// - per-port disable bits 7:4, reset to one, exclude ports.
module video_forwarding_control
    import fwd_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address and data
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // receive ports: a line is pending, sync short packet pending
    input  wire port_mask_t  line_ready,
    input  wire port_mask_t  short_ready,
    input  wire logic        frame_end,
    input  wire logic        sync_lost,
    // output port 0 engine
    input  wire logic        tx_ready,
    output port_mask_t       line_take,
    output port_mask_t       short_take,
    output logic             concat_pkt,
    output logic             pkt_last,
    // interrupt
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  ports_reg;
    logic [7:0]  mode_reg;
    logic [7:0]  irq_mask;
    logic [7:0]  irq_status;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_idx;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        sts_read;
    logic        irq_read;
    logic        synced;
    logic        failure;
    logic        frame_done;
    logic        synced_q;
    logic        failure_q;

    wire port_mask_t enabled = ~ports_reg[`BIT_DIS_HI:`BIT_DIS_LO];
    wire logic [1:0] sync_mode = mode_reg[`BIT_SYNC_HI:`BIT_SYNC_LO];
    wire logic       rr_on = mode_reg[`BIT_RR_EN];
    wire logic       sync_on = (sync_mode != `SYNC_OFF);
    wire logic       as_avail = mode_reg[`BIT_AS_AVAIL] &&
                                (sync_mode != `SYNC_CONCAT);

    ////////////////////////////////////////////////////////////////////////////
    // axi write path: address and data accepted in either order
    wire logic do_write = aw_held && w_held && !s_axi_bvalid;

    // ready flops follow the inverse of the next held state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            aw_idx        <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
        end else begin
            s_axi_awready <= !aw_held;
            s_axi_wready  <= !w_held;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
                aw_idx        <= s_axi_awaddr[9:2];
            end else if (do_write) begin
                aw_held       <= 1'b0;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
            end else if (do_write) begin
                w_held       <= 1'b0;
                s_axi_wready <= 1'b1;
            end
        end
    end

    wire logic addr_ok_w = (aw_idx == `IDX_FWD_PORTS) || (aw_idx == `IDX_FWD_MODE) ||
                           (aw_idx == `IDX_FWD_STATUS) || (aw_idx == `IDX_IRQ_STATUS) ||
                           (aw_idx == `IDX_IRQ_MASK);

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_ok_w ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // a write of the mode register, used to restart the sequencer
    wire logic mode_wr = do_write && wstrb_q[0] && (aw_idx == `IDX_FWD_MODE);
    // mask as it stands after this edge, so irq follows a mask write at once
    wire logic [7:0] next_irq_mask = (do_write && wstrb_q[0] && (aw_idx == `IDX_IRQ_MASK)) ?
                                     wdata_q[7:0] : irq_mask;

    // control registers, byte lane 0 only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ports_reg <= `RST_FWD_PORTS;
            mode_reg  <= `RST_FWD_MODE;
            irq_mask  <= `RST_IRQ_MASK;
        end else if (do_write && wstrb_q[0]) begin
            if (aw_idx == `IDX_FWD_PORTS) begin
                ports_reg <= wdata_q[7:0];
            end
            if (aw_idx == `IDX_FWD_MODE) begin
                mode_reg <= wdata_q[7:0];
            end
            if (aw_idx == `IDX_IRQ_MASK) begin
                irq_mask <= wdata_q[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi read path
    logic [7:0] rd_byte;
    logic       rd_ok;
    always_comb begin
        rd_byte = 8'h00;
        rd_ok   = 1'b1;
        case (s_axi_araddr[9:2])
            `IDX_FWD_PORTS:  rd_byte = ports_reg;
            `IDX_FWD_MODE:   rd_byte = mode_reg;
            `IDX_FWD_STATUS: begin
                rd_byte[`BIT_STS_SYNC] = synced;
                rd_byte[`BIT_STS_FAIL] = failure;
            end
            `IDX_IRQ_STATUS: rd_byte = irq_status;
            `IDX_IRQ_MASK:   rd_byte = irq_mask;
            default:         rd_ok = 1'b0;
        endcase
    end

    wire logic do_read = s_axi_arvalid && s_axi_arready;
    assign sts_read = do_read && (s_axi_araddr[9:2] == `IDX_FWD_STATUS);
    assign irq_read = do_read && (s_axi_araddr[9:2] == `IDX_IRQ_STATUS);

    // read answer; arready is the registered inverse of the next rvalid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid;
            if (do_read) begin
                s_axi_rvalid  <= 1'b1;
                s_axi_arready <= 1'b0;
                s_axi_rdata   <= {24'h00_0000, rd_byte};
                s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // forwarding engine
    fwd_state_t  state;
    port_mask_t  pending;
    port_mask_t  rr_grant;
    port_mask_t  arb_req;
    logic        arb_adv;
    // a source still shows a line for one cycle after it was taken
    wire port_mask_t live = line_ready & enabled & ~line_take;
    wire logic   all_ready = (enabled != 4'h0) && ((live & enabled) == enabled);

    // which ports may compete for the next grant
    always_comb begin
        arb_req = 4'h0;
        if (rr_on && !sync_on) begin
            arb_req = live;
        end else if (sync_on && as_avail) begin
            arb_req = live & pending;
        end else if (sync_on) begin
            arb_req = pending;
        end
    end
    assign arb_adv = tx_ready && (state == ST_SEND) && (arb_req != 4'h0) && !mode_wr;

    rr_arbiter u_arb (
        .aclk    (aclk),
        .aresetn (aresetn),
        .req     (arb_req),
        .advance (arb_adv),
        .grant   (rr_grant)
    );

    // line-set sequencer: pending holds ports still owed a line this round
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state      <= ST_IDLE;
            pending    <= 4'h0;
            line_take  <= 4'h0;
            short_take <= 4'h0;
            concat_pkt <= 1'b0;
            pkt_last   <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            line_take  <= 4'h0;
            concat_pkt <= 1'b0;
            pkt_last   <= 1'b0;
            frame_done <= 1'b0;
            // sync short packets of enabled ports pass as they come whenever tx_ready is high
            short_take <= tx_ready ? (short_ready & enabled) : 4'h0;
            case (state)
                ST_IDLE: begin
                    if (rr_on && !sync_on && live != 4'h0) begin
                        state <= ST_SEND;
                    end else if (sync_on && sync_mode == `SYNC_CONCAT && all_ready) begin
                        state <= ST_CONCAT;
                    end else if (sync_on && (all_ready || (as_avail && live != 4'h0))) begin
                        pending <= enabled;
                        state   <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (arb_adv) begin
                        line_take <= rr_grant;
                        pkt_last  <= 1'b1;
                        pending   <= pending & ~rr_grant;
                        if (!sync_on || (pending & ~rr_grant) == 4'h0) begin
                            state      <= ST_IDLE;
                            frame_done <= sync_on && frame_end;
                        end
                    end else if (!sync_on && !rr_on) begin
                        state <= ST_IDLE;
                    end
                end
                ST_CONCAT: begin
                    if (tx_ready) begin
                        line_take  <= enabled;
                        concat_pkt <= 1'b1;
                        pkt_last   <= 1'b1;
                        frame_done <= frame_end;
                        state      <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // a new mode drops any half-sent line set
            if (mode_wr) begin
                state   <= ST_IDLE;
                pending <= 4'h0;
            end
        end
    end

    sync_tracker u_trk (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .sync_on       (sync_on),
        .frame_sent    (frame_done),
        .sync_lost     (sync_lost),
        .clear_on_read (sts_read),
        .synchronized  (synced),
        .failure       (failure)
    );

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: bit0 failure rise, bit1 sync gained, read clears, set wins
    // previous status levels for edge detection, idle low like the sources
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            synced_q  <= 1'b0;
            failure_q <= 1'b0;
        end else begin
            synced_q  <= synced;
            failure_q <= failure;
        end
    end
    wire logic [7:0] irq_events = {6'h00, synced && !synced_q, failure && !failure_q};
    wire logic [7:0] next_irq_status = irq_events | (irq_read ? 8'h00 : irq_status);

    // sticky status and level output, both from next values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= 8'h00;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq        <= (next_irq_status & next_irq_mask) != 8'h00;
        end
    end

    a_wait_all: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_IDLE && sync_on && !as_avail && !all_ready) |=> (state == ST_IDLE))
        else $error("sync line set started before all ports ready");
    a_concat_all: assert property (@(posedge aclk) disable iff (!aresetn)
        concat_pkt |-> (line_take == enabled))
        else $error("concatenated packet missing enabled ports");
    a_take_enabled: assert property (@(posedge aclk) disable iff (!aresetn)
        ((line_take | short_take) & ~enabled) == 4'h0 || $changed(enabled))
        else $error("disabled port forwarded");
    a_take_one: assert property (@(posedge aclk) disable iff (!aresetn)
        !concat_pkt |-> $onehot0(line_take))
        else $error("more than one line taken outside concatenation");
    a_reset_mode: assert property (@(posedge aclk)
        !aresetn |=> (mode_reg == `RST_FWD_MODE) && (ports_reg == `RST_FWD_PORTS))
        else $error("wrong reset value of control registers");
    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == ((irq_status & irq_mask) != 8'h00))
        else $error("interrupt out of step with status");
endmodule : video_forwarding_control

// File: logic/fwd_consts.svh
`ifndef FWD_CONSTS_SVH
`define FWD_CONSTS_SVH
// register word indices (printed offsets are indices, byte address = 4 * index)
`define IDX_FWD_PORTS      8'h20
`define IDX_FWD_MODE       8'h21
`define IDX_FWD_STATUS     8'h22
`define IDX_IRQ_STATUS     8'h30
`define IDX_IRQ_MASK       8'h31
// field positions
`define BIT_RR_EN          0
`define BIT_RSVD1          1
`define BIT_SYNC_LO        2
`define BIT_SYNC_HI        3
`define BIT_AS_AVAIL       6
`define BIT_DIS_LO         4
`define BIT_DIS_HI         7
`define BIT_STS_SYNC       0
`define BIT_STS_FAIL       2
// reset values
`define RST_FWD_PORTS      8'hf0
`define RST_FWD_MODE       8'h03
`define RST_IRQ_MASK       8'h00
// sync mode codes
`define SYNC_OFF           2'h0
`define SYNC_BASIC         2'h1
`define SYNC_INTERLEAVE    2'h2
`define SYNC_CONCAT        2'h3
// axi responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`define NPORTS             4
`endif

// File: logic/fwd_pkg.sv
package fwd_pkg;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SEND   = 2'b01,
        ST_CONCAT = 2'b10
    } fwd_state_t;
    typedef logic [3:0] port_mask_t;
endpackage : fwd_pkg

// File: logic/rr_arbiter.sv
`timescale 1ns/100ps
`include "fwd_consts.svh"
// round-robin pick of one requesting port, pointer advances past the grant
module rr_arbiter
    import fwd_pkg::*;
(
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // request and grant
    input  wire port_mask_t req,
    input  wire logic       advance,
    output port_mask_t      grant
);
    logic [1:0] last;
    port_mask_t pick;

    // search from the port after the last one served
    always_comb begin
        pick = 4'h0;
        for (int k = `NPORTS; k >= 1; k--) begin
            if (req[2'(int'(last) + k)]) begin
                pick = 4'h0;
                pick[2'(int'(last) + k)] = 1'b1;
            end
        end
    end
    assign grant = pick;

    // remember the port just served
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last <= 2'h3;
        end else if (advance) begin
            for (int k = 0; k < `NPORTS; k++) begin
                if (pick[k]) begin
                    last <= 2'(k);
                end
            end
        end
    end

    a_grant_onehot: assert property (@(posedge aclk) disable iff (!aresetn)
        $onehot0(grant) && ((req != 4'h0) == (grant != 4'h0)))
        else $error("arbiter grant not one-hot or lost");
    a_grant_req: assert property (@(posedge aclk) disable iff (!aresetn)
        (grant & ~req) == 4'h0)
        else $error("grant to port without request");
endmodule : rr_arbiter

// File: logic/sync_tracker.sv
`timescale 1ns/100ps
`include "fwd_consts.svh"
// tracks synchronized delivery and catches its loss
module sync_tracker
    import fwd_pkg::*;
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // events
    input  wire logic sync_on,
    input  wire logic frame_sent,
    input  wire logic sync_lost,
    input  wire logic clear_on_read,
    // status
    output logic      synchronized,
    output logic      failure
);
    logic seen_frame;

    // a synchronized frame arms the failure detector
    always_ff @(posedge aclk) begin
        if (!aresetn || !sync_on) begin
            seen_frame <= 1'b0;
        end else if (frame_sent) begin
            seen_frame <= 1'b1;
        end
    end

    // live synchronized status, zero when sync forwarding is off
    always_ff @(posedge aclk) begin
        if (!aresetn || !sync_on) begin
            synchronized <= 1'b0;
        end else if (sync_lost) begin
            synchronized <= 1'b0;
        end else if (frame_sent) begin
            synchronized <= 1'b1;
        end
    end

    // sticky failure flag, a new loss wins over the clearing read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            failure <= 1'b0;
        end else if (sync_on && sync_lost && seen_frame) begin
            failure <= 1'b1;
        end else if (clear_on_read) begin
            failure <= 1'b0;
        end
    end

    a_fail_armed: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(failure) |-> $past(seen_frame))
        else $error("failure flagged before any synchronized frame");
    a_fail_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        failure && !clear_on_read |=> failure)
        else $error("failure flag dropped without read");
    a_sync_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !sync_on |=> !synchronized)
        else $error("synchronized set while sync forwarding off");
endmodule : sync_tracker

// File: sim/sink_model.sv
`timescale 1ns/100ps
// downstream receiver: takes packets, can stall, keeps the first four taken masks
module sink_model
    import fwd_pkg::*;
(
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // bench control
    input  wire logic       slow,
    input  wire logic       clr,
    // packet side
    input  wire port_mask_t line_take,
    input  wire logic       concat_pkt,
    output logic            tx_ready,
    // packet log
    output port_mask_t      log_take [4],
    output logic            log_cat  [4],
    output logic [3:0]      n_take
);
    logic [1:0] phase;

    ////////////////////////////////////////////////////////////////////////////
    // ready drops one cycle in three when slow, so grants must survive a stall
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase    <= 2'h0;
            tx_ready <= 1'h0;
        end else begin
            phase    <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            tx_ready <= !(slow && phase == 2'h2);
        end
    end

    // record each packet, count saturates
    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            n_take <= 4'h0;
        end else if (line_take != 4'h0) begin
            if (n_take < 4'h4) begin
                log_take[n_take[1:0]] <= line_take;
                log_cat[n_take[1:0]]  <= concat_pkt;
            end
            if (n_take != 4'hf) begin
                n_take <= n_take + 4'h1;
            end
        end
    end
endmodule : sink_model

// File: sim/tb_top.sv
`timescale 1ns/100ps
`include "fwd_consts.svh"
module tb_top
    import fwd_pkg::*;
;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, v;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [3:0]  wstrb = 4'hf;
    port_mask_t  line_ready = 4'h0, nv = 4'h0, short_ready = 4'h0, line_take, short_take;
    logic        ld = 1'h0, frame_end = 1'h0, sync_lost = 1'h0, slow = 1'h0, clr = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, concat_pkt, pkt_last, irq, tx_ready;
    logic [1:0]  bresp, rresp, rs;
    port_mask_t  log_take [4];
    logic        log_cat [4];
    logic [3:0]  n_take;
    int          err_total = 0, check_count = 0, cyc = 0, n_last = 0;

    always #12.5 aclk = ~aclk;

    video_forwarding_control i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .line_ready(line_ready), .short_ready(short_ready), .frame_end(frame_end),
        .sync_lost(sync_lost), .tx_ready(tx_ready), .line_take(line_take),
        .short_take(short_take), .concat_pkt(concat_pkt), .pkt_last(pkt_last), .irq(irq));

    sink_model i_sink (.aclk(aclk), .aresetn(aresetn), .slow(slow), .clr(clr),
        .line_take(line_take), .concat_pkt(concat_pkt), .tx_ready(tx_ready),
        .log_take(log_take), .log_cat(log_cat), .n_take(n_take));

    ////////////////////////////////////////////////////////////////////////////
    // sources: a pending line clears once taken, bench may reload the set
    always_ff @(posedge aclk) begin
        line_ready <= ld ? nv : (line_ready & ~line_take);
    end

    // packet end markers seen over the whole run
    always @(posedge aclk) begin
        if (pkt_last) n_last <= n_last + 1;
    end

    // hang guard
    always @(posedge aclk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            conclude();
        end
    end

    task automatic conclude();
        if (err_total == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic a, w, b;
        @(posedge aclk);
        awaddr <= {22'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(negedge aclk);
            a = awvalid & awready;
            w = wvalid & wready;
            b = bvalid & bready;
            @(posedge aclk);
            if (a) awvalid <= 1'h0;
            if (w) wvalid <= 1'h0;
        end while (!b);
        bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        logic a, b;
        @(posedge aclk);
        araddr <= {22'h0, idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(negedge aclk);
            a = arvalid & arready;
            b = rvalid & rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (a) arvalid <= 1'h0;
        end while (!b);
        rready <= 1'h0;
    endtask : rd

    // load the pending-line set, clear the packet log
    task automatic src(input port_mask_t m);
        @(posedge aclk);
        ld <= 1'h1;
        nv <= m;
        clr <= 1'h1;
        @(posedge aclk);
        ld <= 1'h0;
        clr <= 1'h0;
    endtask : src

    task automatic lose();
        @(posedge aclk);
        sync_lost <= 1'h1;
        @(posedge aclk);
        sync_lost <= 1'h0;
    endtask : lose

    // one mode, one offered set, then a settle window
    task automatic run(input logic [7:0] mode, input port_mask_t m);
        src(4'h0);
        wr(`IDX_FWD_MODE, mode);
        src(m);
        repeat (20) @(posedge aclk);
    endtask : run

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`IDX_FWD_PORTS, v, rs); chk("ports", 32'hf0, v);
        rd(`IDX_FWD_MODE, v, rs); chk("mode", 32'h03, v);
        rd(`IDX_FWD_STATUS, v, rs); chk("status", 32'h0, v);
        rd(`IDX_IRQ_MASK, v, rs); chk("mask", 32'h0, v);
        rd(8'h40, v, rs); chk("unmapped", 32'(`RESP_SLVERR), 32'(rs));
        // round robin, ports 2 and 3 disabled, stalling sink
        wr(`IDX_FWD_PORTS, 8'hc0);
        slow <= 1'h1;
        src(4'h7);
        repeat (30) @(posedge aclk);
        chk("rr set", 32'h3, 32'(log_take[0] | log_take[1]));
        chk("rr turn", 32'h1, 32'(log_take[0] != log_take[1]));
        rd(`IDX_FWD_STATUS, v, rs); chk("rr sync", 32'h0, v & 32'h1);
        slow <= 1'h0;
        run(8'h04, 4'h1); chk("hold", 32'h0, 32'(n_take));
        src(4'h3);
        repeat (20) @(posedge aclk);
        chk("basic", 32'h3, 32'(log_take[0] | log_take[1]));
        run(8'h08, 4'h3); chk("ilv", 32'h3, 32'({log_cat[0], log_take[0] ^ log_take[1]}));
        run(8'h44, 4'h1); chk("avail", 32'h1, 32'(log_take[0]));
        run(8'h4c, 4'h1); chk("cat hold", 32'h0, 32'(n_take));
        @(posedge aclk);
        short_ready <= 4'h5;
        repeat (2) @(negedge aclk);
        chk("short", 32'h1, 32'(short_take));
        @(posedge aclk);
        short_ready <= 4'h0;
        src(4'h3);
        repeat (20) @(posedge aclk);
        chk("cat", 32'h13, 32'({log_cat[0], log_take[0]}));
        chk("cat count", 32'h1, 32'(n_take));
        // failure needs a synced frame first
        run(8'h04, 4'h0);
        lose();
        rd(`IDX_FWD_STATUS, v, rs); chk("early fail", 32'h0, v);
        frame_end <= 1'h1;
        src(4'h3);
        repeat (20) @(posedge aclk);
        frame_end <= 1'h0;
        rd(`IDX_FWD_STATUS, v, rs); chk("synced", 32'h1, v);
        chk("irq masked", 32'h0, 32'(irq));
        wr(`IDX_IRQ_MASK, 8'h01);
        lose();
        repeat (2) @(negedge aclk);
        chk("irq", 32'h1, 32'(irq));
        rd(`IDX_FWD_STATUS, v, rs); chk("fail", 32'h04, v);
        rd(`IDX_FWD_STATUS, v, rs); chk("fail clr", 32'h0, v);
        rd(`IDX_IRQ_STATUS, v, rs); chk("irq sts", 32'h3, v);
        repeat (2) @(negedge aclk);
        chk("irq clr", 32'h0, 32'(irq));
        @(posedge aclk);
        // synced bit drops once synced forwarding is off
        frame_end <= 1'h1;
        src(4'h3);
        repeat (20) @(posedge aclk);
        frame_end <= 1'h0;
        rd(`IDX_FWD_STATUS, v, rs); chk("resync", 32'h1, v);
        wr(`IDX_FWD_MODE, 8'h01);
        rd(`IDX_FWD_STATUS, v, rs); chk("off", 32'h0, v);
        chk("packets", 32'hc, 32'(n_last));
        conclude();
    end
endmodule : tb_top
